// >>> rtl/clock_generator_unit.sv
`timescale 1ns/1ns
`include "clock_generator_unit_defs.svh"

module clock_generator_unit
    import clock_generator_unit_pkg::*;
(
    input  wire logic       i_core_clk,     // Crystal clock, 10 MHz.
    input  wire logic       i_rst_n,        // Asynchronous reset, active low.
    input  wire reg_req_s   i_reg,          // Register bus request.
    output logic      [7:0] o_rdata,        // Read data, cycle after the read strobe.
    input  wire sysint_s    i_sysint,       // Levels from the integration unit.
    input  wire logic       i_vco_tick,     // One-cycle pulse per VCO clock edge.
    input  wire logic [7:0] i_freq_error,   // Loop frequency error magnitude.
    output logic            o_crystal_clock_out, // Crystal half rate, low in stop.
    output logic            o_base_clock_out,    // Selected half rate, low in stop.
    output logic            o_clockgen_interrupt // Level interrupt, low in stop.
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_pipe;
    logic       rst_n_sync;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n_sync = rst_pipe[1];

    // ****************************************************************
    // Next state
    // ****************************************************************
    cgu_state_s r;
    cgu_state_s next_r;

    logic osc_en;
    logic in_break_protected;
    logic ctl_read;
    logic ctl_write;
    logic bw_write;
    logic next_track_raw;
    logic next_lock_raw;
    logic lock_toggled;
    logic track_entry;
    logic stop_reselect;

    always_comb
    begin
        osc_en             = i_sysint.oscillator_enable_from_sysint;
        in_break_protected = i_sysint.break_state && !i_sysint.break_clear_enable;
        ctl_read           = i_reg.rd && (i_reg.addr == `CGU_ADDR_LOOP_CONTROL);
        ctl_write          = i_reg.wr && (i_reg.addr == `CGU_ADDR_LOOP_CONTROL);
        bw_write           = i_reg.wr && (i_reg.addr == `CGU_ADDR_LOOP_BANDWIDTH);
        next_r             = r;
        next_r.rdata       = 8'h00;

        // Register writes; the wait level is never consulted, so wait changes nothing.
        if (ctl_write)
        begin
            next_r.irq_en = i_reg.wdata[`CGU_CTL_IRQ_EN_BIT];
            // The loop cannot be switched off while it drives the base clock.
            if (i_reg.wdata[`CGU_CTL_POWER_ON_BIT] || !r.base_clock_source_select)
            begin
                next_r.loop_power_on = i_reg.wdata[`CGU_CTL_POWER_ON_BIT];
            end
            // The VCO cannot be selected while the loop is off.
            if (!i_reg.wdata[`CGU_CTL_BASE_SEL_BIT] || r.loop_power_on)
            begin
                next_r.base_clock_source_select = i_reg.wdata[`CGU_CTL_BASE_SEL_BIT];
            end
        end
        else if (bw_write)
        begin
            next_r.auto_mode = i_reg.wdata[`CGU_BW_AUTO_BIT];
            if (!r.auto_mode)
            begin
                next_r.tracking_manual = i_reg.wdata[`CGU_BW_TRACK_BIT];
            end
        end
        else if (i_reg.wr && (i_reg.addr == `CGU_ADDR_EVENT_STATUS))
        begin
            next_r.event_status = r.event_status & ~i_reg.wdata[`CGU_EVT_WIDTH-1:0];
        end
        else if (i_reg.wr && (i_reg.addr == `CGU_ADDR_EVENT_MASK))
        begin
            next_r.event_mask = i_reg.wdata[`CGU_EVT_WIDTH-1:0];
        end

        // Reads.
        if (i_reg.rd)
        begin
            if (i_reg.addr == `CGU_ADDR_LOOP_CONTROL)
            begin
                next_r.rdata = {r.irq_en, r.loop_change_flag && r.auto_mode,
                                r.loop_power_on, r.base_clock_source_select,
                                `CGU_CTL_RESERVED_READ};
            end
            else if (i_reg.addr == `CGU_ADDR_LOOP_BANDWIDTH)
            begin
                next_r.rdata = {r.auto_mode, r.lock && r.auto_mode,
                                r.auto_mode ? r.tracking_auto : r.tracking_manual, 5'h00};
            end
            else if (i_reg.addr == `CGU_ADDR_EVENT_STATUS)
            begin
                next_r.rdata = {5'h00, r.event_status};
            end
            else if (i_reg.addr == `CGU_ADDR_EVENT_MASK)
            begin
                next_r.rdata = {5'h00, r.event_mask};
            end
            else
            begin
                next_r.rdata = 8'h00;
            end
        end

        // Change flag clear by a control read, blocked in protected break.
        if (ctl_read && !in_break_protected)
        begin
            next_r.loop_change_flag = 1'b0;
        end

        // Automatic bandwidth status from the frequency error.
        next_track_raw = r.auto_mode && r.loop_power_on && osc_en
                         && (i_freq_error < `CGU_TRACK_TOLERANCE);
        next_lock_raw  = r.auto_mode && r.loop_power_on && osc_en
                         && (i_freq_error < `CGU_LOCK_TOLERANCE);
        lock_toggled   = r.auto_mode && (next_lock_raw != r.lock);
        track_entry    = next_track_raw && !r.tracking_auto;
        next_r.tracking_auto = next_track_raw;
        next_r.lock          = next_lock_raw;
        if (lock_toggled)
        begin
            next_r.loop_change_flag = 1'b1;
        end

        // Stop forces the crystal source back.
        stop_reselect = !osc_en && r.base_clock_source_select;
        if (!osc_en)
        begin
            next_r.base_clock_source_select = 1'b0;
        end

        // Events set after any clear so a simultaneous set wins.
        if (lock_toggled)
        begin
            next_r.event_status[`CGU_EVT_LOCK_CHANGE] = 1'b1;
        end
        if (track_entry)
        begin
            next_r.event_status[`CGU_EVT_TRACK_ENTRY] = 1'b1;
        end
        if (stop_reselect)
        begin
            next_r.event_status[`CGU_EVT_STOP_RESELECT] = 1'b1;
        end

        // Clock dividers, held low while stopped.
        if (!osc_en)
        begin
            next_r.crystal_div = 1'b0;
            next_r.base_div    = 1'b0;
        end
        else
        begin
            next_r.crystal_div = !r.crystal_div;
            if (r.base_clock_source_select)
            begin
                next_r.base_div = i_vco_tick ? !r.base_div : r.base_div;
            end
            else
            begin
                next_r.base_div = !r.base_div;
            end
        end

        next_r.irq = osc_en && ((|(next_r.event_status & next_r.event_mask))
                     || (next_r.irq_en && next_r.loop_change_flag && next_r.auto_mode));
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            r                 <= '0;
            r.loop_power_on   <= `CGU_RST_POWER_ON;
            r.event_mask      <= `CGU_RST_MASK;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_rdata              = r.rdata;
    assign o_crystal_clock_out  = r.crystal_div;
    assign o_base_clock_out     = r.base_div;
    assign o_clockgen_interrupt = r.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n_sync);

    a_wait_no_effect: assert property (
        i_sysint.wait_mode && osc_en && !i_reg.wr && !$changed(i_sysint.wait_mode)
        |=> $stable(r.base_clock_source_select) && $stable(r.loop_power_on))
        else $error("Wait changed the generator setup.");

    a_stop_outputs_low: assert property (
        !osc_en |=> !o_crystal_clock_out && !o_base_clock_out && !o_clockgen_interrupt)
        else $error("Outputs not held low in stop.");

    a_stop_clears_select: assert property (
        !osc_en && r.base_clock_source_select |=> !r.base_clock_source_select
        ##0 r.event_status[`CGU_EVT_STOP_RESELECT])
        else $error("Stop did not clear base clock select.");

    a_recover_crystal: assert property (
        $rose(osc_en) && !r.base_clock_source_select && !i_reg.wr
        |=> !r.base_clock_source_select ##1 $changed(o_base_clock_out))
        else $error("Base clock not crystal half rate after stop.");

    a_break_keeps_flag: assert property (
        ctl_read && in_break_protected && r.loop_change_flag
        |=> r.loop_change_flag)
        else $error("Change flag altered during protected break.");

    a_read_clears_flag: assert property (
        ctl_read && !in_break_protected && !lock_toggled |=> !r.loop_change_flag)
        else $error("Control read did not clear change flag.");

    a_cleared_stays: assert property (
        ctl_read && i_sysint.break_state && i_sysint.break_clear_enable && !lock_toggled
        ##1 !lock_toggled[*2] |-> !r.loop_change_flag)
        else $error("Flag cleared in break came back.");

    a_lock_sets_flag: assert property (
        r.auto_mode && $changed(r.lock) |-> r.loop_change_flag
        && r.event_status[`CGU_EVT_LOCK_CHANGE])
        else $error("Lock toggle did not set change flag.");

    a_track_entry: assert property (
        r.auto_mode && r.loop_power_on && osc_en
        && (i_freq_error < `CGU_TRACK_TOLERANCE) |=> r.tracking_auto)
        else $error("Tracking status not set below tolerance.");

    a_lock_entry: assert property (
        r.auto_mode && r.loop_power_on && osc_en
        && (i_freq_error < `CGU_LOCK_TOLERANCE) |=> r.lock)
        else $error("Lock not set below tolerance.");

    a_vco_source: assert property (
        osc_en && r.base_clock_source_select && !i_vco_tick
        && $past(osc_en) |=> $stable(o_base_clock_out))
        else $error("Base clock moved without a VCO edge.");

    // ****************************************************************
    // Protection and status checks
    // ****************************************************************
    a_power_kept: assert property (
        ctl_write && r.base_clock_source_select && !i_reg.wdata[`CGU_CTL_POWER_ON_BIT]
        |=> r.loop_power_on)
        else $error("Loop powered off while driving the base clock.");

    a_select_refused: assert property (
        ctl_write && i_reg.wdata[`CGU_CTL_BASE_SEL_BIT] && !r.loop_power_on
        |=> !r.base_clock_source_select)
        else $error("VCO selected while the loop was off.");

    a_select_stays_clear: assert property (
        !r.base_clock_source_select && !ctl_write
        |=> !r.base_clock_source_select)
        else $error("Base clock select set without a write.");

    a_crystal_runs: assert property (
        rst_n_sync && osc_en
        |=> $changed(o_crystal_clock_out))
        else $error("Crystal clock output did not toggle.");

    a_base_half_rate: assert property (
        rst_n_sync && osc_en && !r.base_clock_source_select
        |=> $changed(o_base_clock_out))
        else $error("Base clock not at crystal half rate.");

    a_irq_from_flag: assert property (
        $past(osc_en) && r.irq_en && r.loop_change_flag && r.auto_mode
        |-> o_clockgen_interrupt)
        else $error("Change flag interrupt not raised.");

    a_lock_needs_auto: assert property (
        !$past(r.auto_mode)
        |-> !r.lock)
        else $error("Lock indicator set outside automatic mode.");

    a_track_needs_auto: assert property (
        !$past(r.auto_mode)
        |-> !r.tracking_auto)
        else $error("Tracking status set outside automatic mode.");

    a_break_write_keeps: assert property (
        ctl_write && in_break_protected && r.loop_change_flag
        |=> r.loop_change_flag)
        else $error("Control write in protected break altered the flag.");

    a_flag_hidden_manual: assert property (
        ctl_read && !r.auto_mode
        |=> !o_rdata[`CGU_CTL_CHANGE_FLAG_BIT])
        else $error("Change flag visible in manual mode.");

    c_stop_reselect: cover property (!osc_en && r.base_clock_source_select);
    c_lock_toggle:   cover property (r.auto_mode && $rose(r.lock));
    c_break_protect: cover property (ctl_read && in_break_protected && r.loop_change_flag);
    c_irq_raised:    cover property ($rose(o_clockgen_interrupt));
    c_break_cleared: cover property (ctl_read && i_sysint.break_state
                                     && i_sysint.break_clear_enable);

endmodule : clock_generator_unit

// >>> rtl/clock_generator_unit_defs.svh
`ifndef CLOCK_GENERATOR_UNIT_DEFS_SVH
`define CLOCK_GENERATOR_UNIT_DEFS_SVH

// Register offsets.
`define CGU_ADDR_LOOP_CONTROL    4'h0
`define CGU_ADDR_LOOP_BANDWIDTH  4'h1
`define CGU_ADDR_EVENT_STATUS    4'h2
`define CGU_ADDR_EVENT_MASK      4'h3

// Loop control register fields.
`define CGU_CTL_IRQ_EN_BIT       7
`define CGU_CTL_CHANGE_FLAG_BIT  6
`define CGU_CTL_POWER_ON_BIT     5
`define CGU_CTL_BASE_SEL_BIT     4
`define CGU_CTL_RESERVED_READ    4'hF

// Loop bandwidth register fields.
`define CGU_BW_AUTO_BIT          7
`define CGU_BW_LOCK_BIT          6
`define CGU_BW_TRACK_BIT         5

// Event status and mask fields.
`define CGU_EVT_LOCK_CHANGE      0
`define CGU_EVT_TRACK_ENTRY      1
`define CGU_EVT_STOP_RESELECT    2
`define CGU_EVT_WIDTH            3

// Reset values.
`define CGU_RST_POWER_ON         1'b1
`define CGU_RST_MASK             3'h0

// Frequency error tolerances, in error code units.
`define CGU_TRACK_TOLERANCE      8'h20
`define CGU_LOCK_TOLERANCE       8'h08

`endif

// >>> rtl/clock_generator_unit_pkg.sv
package clock_generator_unit_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic       wait_mode;
        logic       oscillator_enable_from_sysint;
        logic       break_state;
        logic       break_clear_enable;
    } sysint_s;

    typedef struct packed {
        logic       irq_en;
        logic       loop_change_flag;
        logic       loop_power_on;
        logic       base_clock_source_select;
        logic       auto_mode;
        logic       lock;
        logic       tracking_auto;
        logic       tracking_manual;
        logic [2:0] event_status;
        logic [2:0] event_mask;
        logic [7:0] rdata;
        logic       crystal_div;
        logic       base_div;
        logic       irq;
    } cgu_state_s;

endpackage : clock_generator_unit_pkg

// >>> tb/integration_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Integration unit stand-in: low-power, break and VCO edge sources
// ****************************************************************
module integration_model
    import clock_generator_unit_pkg::*;
(
    input  wire logic i_core_clk,  // Crystal clock.
    input  wire logic i_stop_req,  // Software runs the stop instruction.
    input  wire logic i_wait_req,  // Software runs the wait instruction.
    input  wire logic i_break_req, // Debugger holds the break state.
    input  wire logic i_clear_en,  // Break clear enable setting.
    input  wire logic i_vco_run,   // VCO edges present.
    output sysint_s   o_sysint,    // Levels to the generator.
    output logic      o_vco_tick   // One pulse every third cycle.
);
    logic [1:0] phase = 2'h0;

    always_ff @(posedge i_core_clk)
    begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    end

    assign o_vco_tick = i_vco_run && (phase == 2'h0);
    // The oscillator enable falls for as long as stop lasts.
    assign o_sysint = '{wait_mode: i_wait_req,
                        oscillator_enable_from_sysint: !i_stop_req,
                        break_state: i_break_req,
                        break_clear_enable: i_clear_en};
endmodule : integration_model

// >>> tb/testbench.sv
`timescale 1ns/1ns
`include "clock_generator_unit_defs.svh"
module testbench
    import clock_generator_unit_pkg::*;
;
    logic       clk, rst_n, vco_tick, crys, base, irq;
    logic       stop, wt, brk, clr, vrun;
    logic [7:0] ferr, rdata, d;
    logic [7:0] corner [4] = '{8'h07, 8'h08, 8'h1F, 8'h20};
    logic [31:0] seed = 32'hE1B0F1B2;
    reg_req_s   req;
    sysint_s    si;
    int         err_count = 0;
    int         comparisons = 0;

    clock_generator_unit clock_generator_unit_i(.i_core_clk(clk), .i_rst_n(rst_n), .i_reg(req),
        .o_rdata(rdata), .i_sysint(si), .i_vco_tick(vco_tick), .i_freq_error(ferr),
        .o_crystal_clock_out(crys), .o_base_clock_out(base), .o_clockgen_interrupt(irq));
    integration_model integration_model_i(.i_core_clk(clk), .i_stop_req(stop), .i_wait_req(wt),
        .i_break_req(brk), .i_clear_en(clr), .i_vco_run(vrun), .o_sysint(si),
        .o_vco_tick(vco_tick));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic logic [7:0] exp_bw(input logic [7:0] e);
        return {1'b1, e < `CGU_LOCK_TOLERANCE, e < `CGU_TRACK_TOLERANCE, 5'h00};
    endfunction : exp_bw

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask : rd

    task automatic base_count(input int n, input int exp, input string name);
        logic prev;
        int   cnt;
        cnt = 0;
        @(posedge clk);
        #1 prev = base;
        repeat (n)
        begin
            @(posedge clk);
            #1 cnt += int'(base !== prev);
            prev = base;
        end
        check(name, 8'(cnt), 8'(exp));
        @(posedge clk);
    endtask : base_count

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    initial
    begin
        rst_n = 1'b0; req = '0; ferr = 8'hFF;
        {stop, wt, brk, clr, vrun} = 5'b00000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h0, d); check("ctl_reset", d, 8'h2F);
        for (int a = 1; a < 16; a++)
        begin
            rd(4'(a), d); check("reg_reset", d, 8'h00);
        end
        base_count(6, 6, "base_xtal");
        $display("test reset done");
        wt <= 1'b1;
        base_count(6, 6, "base_wait");
        rd(4'h0, d); check("ctl_wait", d, 8'h2F);
        wt <= 1'b0;
        wr(4'h0, 8'h30);
        repeat (4) @(posedge clk);
        base_count(6, 0, "base_vco_idle");
        vrun <= 1'b1;
        repeat (4) @(posedge clk);
        base_count(12, 4, "base_vco");
        wr(4'h0, 8'h10);
        rd(4'h0, d); check("ctl_keep_on", d, 8'h3F);
        $display("test select done");
        wr(4'h3, 8'h04);
        stop <= 1'b1;
        repeat (3) @(posedge clk);
        repeat (6)
        begin
            @(posedge clk);
            #1 check("stop_out", {5'h00, crys, base, irq}, 8'h00);
        end
        @(posedge clk);
        stop <= 1'b0;
        repeat (3) @(posedge clk);
        base_count(9, 9, "base_recover");
        rd(4'h0, d); check("ctl_recover", d, 8'h2F);
        rd(4'h2, d); check("evt_reselect", d, 8'h04);
        #1 check("irq_on", {7'h00, irq}, 8'h01);
        wr(4'h3, 8'h00); @(posedge clk); #1 check("irq_mask", {7'h00, irq}, 8'h00);
        wr(4'h3, 8'h04); wr(4'h2, 8'h04); @(posedge clk);
        #1 check("irq_clr", {7'h00, irq}, 8'h00);
        $display("test stop done");
        wr(4'h0, 8'h20);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h10);
        wt <= 1'b1;
        rd(4'h0, d); check("ctl_off", d, 8'h0F);
        base_count(6, 6, "base_off_wait");
        wt <= 1'b0;
        wr(4'h0, 8'h20);
        $display("test power done");
        wr(4'h1, 8'h80);
        for (int i = 0; i < 28; i++)
        begin
            seed = xs(seed);
            ferr <= (i < 4) ? corner[i] : seed[7:0] >> seed[9:8];
            repeat (3) @(posedge clk);
            rd(4'h1, d); check("bw_status", d, exp_bw(ferr));
        end
        ferr <= 8'hFF;
        repeat (3) @(posedge clk);
        rd(4'h0, d);
        ferr <= 8'h04;
        repeat (3) @(posedge clk);
        rd(4'h0, d); check("flag_set", d, 8'h6F);
        rd(4'h0, d); check("flag_read_clr", d, 8'h2F);
        $display("test auto done");
        brk <= 1'b1; ferr <= 8'hFF;
        repeat (3) @(posedge clk);
        rd(4'h0, d); check("brk_keep1", d, 8'h6F);
        wr(4'h0, 8'h20);
        rd(4'h0, d); check("brk_keep2", d, 8'h6F);
        brk <= 1'b0;
        rd(4'h0, d); check("brk_exit_rd", d, 8'h6F);
        rd(4'h0, d); check("brk_exit_clr", d, 8'h2F);
        clr <= 1'b1; brk <= 1'b1; ferr <= 8'h04;
        repeat (3) @(posedge clk);
        rd(4'h0, d); check("brk_clr_set", d, 8'h6F);
        rd(4'h0, d); check("brk_clr_done", d, 8'h2F);
        brk <= 1'b0;
        rd(4'h0, d); check("brk_stay_clr", d, 8'h2F);
        wr(4'h0, 8'hA0);
        ferr <= 8'hFF;
        repeat (3) @(posedge clk);
        #1 check("irq_flag", {7'h00, irq}, 8'h01);
        rd(4'h0, d); check("ctl_irq", d, 8'hEF);
        #1 check("irq_flag_clr", {7'h00, irq}, 8'h00);
        $display("test break done");
        wrap_up();
    end
endmodule : testbench
